//--- rtl/adc_seq_ram.sv
// constants for the converter sequencer and its small two-read-port memory
package adc_seq_pkg;
  // =====================================================================
  // register map (byte addresses on the bus)
  localparam logic [11:0] REG_CTRL_ONE = 12'h000;
  localparam logic [11:0] REG_IRQ_STATUS = 12'h004;
  localparam logic [11:0] REG_IRQ_MASK = 12'h008;
  localparam logic [11:0] REG_TOP_IRQ = 12'h00c;
  localparam logic [11:0] REG_TOP_MASK = 12'h010;
  localparam logic [11:0] REG_VENDOR_CTRL = 12'h014;
  localparam logic [11:0] REG_CHAN_ENABLE = 12'h018;
  localparam logic [11:0] REG_SEQ_STATUS = 12'h01c;
  localparam logic [11:0] TABLE_BASE = 12'h080;
  localparam logic [11:0] RESULT_BASE = 12'h100;
  // =====================================================================
  // field positions and reset values
  localparam int EN_BIT = 0;
  localparam int START_BIT = 1;
  localparam int SLEEP_LSB = 2;
  localparam int DONE_BIT = 0;
  localparam int TOP_ROUND_BIT = 1;
  localparam int UNIT_BIT = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [3:0] CHAN_EN_RESET = 4'h0;
  localparam logic UNIT_RESET = 1'b0;
  localparam logic [4:0] END_MARKER = 5'h1f;
  localparam int ENTRIES = 32;
  localparam int SEL_W = 5;
  localparam int ENTRY_W = 8;
  localparam int CODE_W = 10;
  localparam int RESULT_W = 11;
  // =====================================================================
  // timing: 32.768 kHz time base from the core clock
  localparam int CLK_HZ = 20000000;
  localparam int TB_HZ = 32768;
  localparam int TB_DIV = CLK_HZ / TB_HZ;
  localparam int ROUND_US = 15625;
  localparam int ROUND_TICKS = ROUND_US * TB_HZ / 1000000;
  localparam int SLOT_TICKS = ROUND_TICKS / ENTRIES;
  localparam int SLEEP_MS [8] = '{0, 1, 2, 4, 8, 12, 20, 27};
  // =====================================================================
  // sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_LOAD = 3'b001,
    ST_DECODE = 3'b010,
    ST_PLL = 3'b011,
    ST_CONV = 3'b100,
    ST_SLOT = 3'b101,
    ST_SLEEP = 3'b110
  } seq_state_t;
endpackage

`timescale 1ns/1ps
`default_nettype none
module adc_seq_ram #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32,
  parameter int AW = 5
) (
  // clock
  input wire logic clk,
  // write port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  // two registered read ports
  input wire logic [AW-1:0] raddr_a,
  output logic [WIDTH-1:0] rdata_a,
  input wire logic [AW-1:0] raddr_b,
  output logic [WIDTH-1:0] rdata_b
);
  logic [WIDTH-1:0] mem [DEPTH];

  // write, then registered reads (old data on a same-address collision)
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata_a <= mem[raddr_a];
    rdata_b <= mem[raddr_b];
  end
endmodule
`default_nettype wire

//--- rtl/adc_round_robin_sequencer.sv
// round-robin converter sequencer with a wishbone register file
// Behaviour
// - channel table holds 32 entries of five address bits plus three bias bits
// - result file holds 32 entries of ten code bits plus one
// - with start set the table is walked in order, converting each entry
// - three upper entry bits drive the touch bias switches during that step
// - low five bits choose one of 32 inputs, codes 10..21 general purpose
// - each result carries the gain setting as its top bit
// - an entry with address 0x1F ends the round without converting
// - round end sets done flag bit 0, gated by its mask bit
// - round end sets top bit 1; irq out only if top mask bit 1 clear
// - after a round sleep 0 to 27 ms by sleep field, then restart if start is still set, else go idle
// - new results overwrite the previous round directly
// - a full round of 32 conversions fits in 15.625 ms
// - optional channels 22, 24, 25, 26 connect only when enabled
// - result unit select resets to 0, native converter steps
// - unit select 1 gives round units for dedicated channels
// - full code range spans the 2.40 V scaled input
// - table entry address is its five-bit select field
// - events are timed from a 32.768 kHz time base
// - an inactive pll is requested before converting
`timescale 1ns/1ps
`default_nettype none
module adc_round_robin_sequencer
  import adc_seq_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // converter core
  output logic conv_power_en,
  output logic conv_req,
  output logic [4:0] conv_chan,
  output logic [2:0] bias_sw,
  output logic result_unit_select,
  output logic [3:0] alt_chan_en,
  input wire logic conv_done,
  input wire logic [9:0] conv_data,
  input wire logic conv_gain,
  // pll
  output logic pll_req,
  input wire logic pll_active,
  // chip interrupt
  output logic chip_irq_out
);
  // ===================================================================
  // declarations
  logic [7:0] conv_ctrl_one;
  logic round_done_flag, round_done_mask, top_flag, top_mask;
  logic busy, pll_meta, pll_sync, done_pulse, tb_tick;
  logic [9:0] tb_cnt;
  logic [9:0] sleep_cnt;
  logic [4:0] slot_ticks;
  logic [4:0] idx;
  seq_state_t state;
  logic [ENTRY_W-1:0] tbl_seq_q, tbl_bus_q;
  logic [RESULT_W-1:0] res_bus_q, res_seq_q;
  logic [RESULT_W-1:0] res_wdata;
  logic res_we, bus_wr, in_table, in_result, conv_enable_bit, round_start_bit;
  logic [31:0] next_rdata;

  // seq sleep count in time-base ticks for a sleep field code
  function automatic logic [9:0] sleep_ticks(input logic [2:0] code);
    sleep_ticks = 10'(SLEEP_MS[code] * TB_HZ / 1000);
  endfunction

  assign conv_enable_bit = conv_ctrl_one[EN_BIT];
  assign round_start_bit = conv_ctrl_one[START_BIT];

  // ===================================================================
  // wishbone: request seen, ram read, then ack with registered data
  assign bus_wr = busy & wb_we_i & wb_sel_i[0];
  assign in_table = wb_adr_i[11:7] == TABLE_BASE[11:7];
  assign in_result = wb_adr_i[11:7] == RESULT_BASE[11:7];

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      busy <= 1'b0;
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= busy;
      busy <= wb_cyc_i & wb_stb_i & ~busy & ~wb_ack_o;
    end
  end

  // read mux, unmapped addresses read as zero
  always_comb begin
    next_rdata = 32'h0;
    if (in_table) begin
      next_rdata = {24'h0, tbl_bus_q};
    end else if (in_result) begin
      next_rdata = {21'h0, res_bus_q};
    end else begin
      case (wb_adr_i)
        REG_CTRL_ONE: next_rdata = {24'h0, conv_ctrl_one};
        REG_IRQ_STATUS: next_rdata = {31'h0, round_done_flag};
        REG_IRQ_MASK: next_rdata = {31'h0, round_done_mask};
        REG_TOP_IRQ: next_rdata = {30'h0, top_flag, 1'b0};
        REG_TOP_MASK: next_rdata = {30'h0, top_mask, 1'b0};
        REG_VENDOR_CTRL: next_rdata = {31'h0, result_unit_select};
        REG_CHAN_ENABLE: next_rdata = {28'h0, alt_chan_en};
        REG_SEQ_STATUS: next_rdata = {24'h0, state, idx};
        default: next_rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wb_dat_o <= 32'h0;
    end else if (busy) begin
      wb_dat_o <= next_rdata;
    end
  end

  // ===================================================================
  // control registers written by software
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      conv_ctrl_one <= CTRL_RESET;
      round_done_mask <= 1'b0;
      top_mask <= 1'b0;
      result_unit_select <= UNIT_RESET;
      alt_chan_en <= CHAN_EN_RESET;
    end else if (bus_wr) begin
      case (wb_adr_i)
        REG_CTRL_ONE: conv_ctrl_one <= wb_dat_i[7:0];
        REG_IRQ_MASK: round_done_mask <= wb_dat_i[DONE_BIT];
        REG_TOP_MASK: top_mask <= wb_dat_i[TOP_ROUND_BIT];
        REG_VENDOR_CTRL: result_unit_select <= wb_dat_i[UNIT_BIT];
        REG_CHAN_ENABLE: alt_chan_en <= wb_dat_i[3:0];
        default: ;
      endcase
    end
  end

  // converter power follows the enable bit
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      conv_power_en <= 1'b0;
    end else begin
      conv_power_en <= conv_enable_bit;
    end
  end

  // ===================================================================
  // sticky flags, write one to clear, a new set wins over the clear
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      round_done_flag <= 1'b0;
      top_flag <= 1'b0;
    end else begin
      round_done_flag <= done_pulse | (round_done_flag & ~(bus_wr &&
        wb_adr_i == REG_IRQ_STATUS && wb_dat_i[DONE_BIT]));
      top_flag <= done_pulse | (top_flag & ~(bus_wr &&
        wb_adr_i == REG_TOP_IRQ && wb_dat_i[TOP_ROUND_BIT]));
    end
  end

  // chip interrupt from both flag/mask pairs
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      chip_irq_out <= 1'b0;
    end else begin
      chip_irq_out <= round_done_flag & ~round_done_mask & top_flag & ~top_mask;
    end
  end

  // ===================================================================
  // pll status synchroniser
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pll_meta <= 1'b0;
      pll_sync <= 1'b0;
    end else begin
      pll_meta <= pll_active;
      pll_sync <= pll_meta;
    end
  end

  // time base divider, one-cycle tick
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      tb_cnt <= 10'h0;
      tb_tick <= 1'b0;
    end else begin
      tb_tick <= tb_cnt == 10'(TB_DIV - 1);
      tb_cnt <= (tb_cnt == 10'(TB_DIV - 1)) ? 10'h0 : tb_cnt + 10'h1;
    end
  end

  // ===================================================================
  // table and result memories
  adc_seq_ram #(.WIDTH(ENTRY_W), .DEPTH(ENTRIES), .AW(SEL_W)) u_table (
    .clk(core_clk),
    .we(bus_wr && in_table),
    .waddr(wb_adr_i[6:2]),
    .wdata(wb_dat_i[ENTRY_W-1:0]),
    .raddr_a(idx),
    .rdata_a(tbl_seq_q),
    .raddr_b(wb_adr_i[6:2]),
    .rdata_b(tbl_bus_q)
  );

  assign res_we = (state == ST_CONV) && conv_done;
  assign res_wdata = {conv_gain, conv_data};

  adc_seq_ram #(.WIDTH(RESULT_W), .DEPTH(ENTRIES), .AW(SEL_W)) u_result (
    .clk(core_clk),
    .we(res_we),
    .waddr(idx),
    .wdata(res_wdata),
    .raddr_a(idx),
    .rdata_a(res_seq_q),
    .raddr_b(wb_adr_i[6:2]),
    .rdata_b(res_bus_q)
  );

  // ===================================================================
  // sequencer
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_IDLE;
      idx <= 5'h0;
      slot_ticks <= 5'h0;
      sleep_cnt <= 10'h0;
      conv_req <= 1'b0;
      conv_chan <= 5'h0;
      bias_sw <= 3'h0;
      pll_req <= 1'b0;
      done_pulse <= 1'b0;
    end else if (!conv_enable_bit) begin
      state <= ST_IDLE;
      idx <= 5'h0;
      conv_req <= 1'b0;
      bias_sw <= 3'h0;
      pll_req <= 1'b0;
      done_pulse <= 1'b0;
    end else begin
      done_pulse <= 1'b0;
      conv_req <= 1'b0;
      if (tb_tick && slot_ticks != 5'h1f) begin
        slot_ticks <= slot_ticks + 5'h1;
      end
      case (state)
        ST_IDLE: begin
          if (round_start_bit) begin
            idx <= 5'h0;
            state <= ST_LOAD;
          end
        end
        ST_LOAD: state <= ST_DECODE;
        ST_DECODE: begin
          if (tbl_seq_q[SEL_W-1:0] == END_MARKER) begin
            done_pulse <= 1'b1;
            bias_sw <= 3'h0;
            pll_req <= 1'b0;
            sleep_cnt <= sleep_ticks(conv_ctrl_one[SLEEP_LSB +: 3]);
            state <= ST_SLEEP;
          end else begin
            conv_chan <= tbl_seq_q[SEL_W-1:0];
            bias_sw <= tbl_seq_q[ENTRY_W-1:SEL_W];
            slot_ticks <= 5'h0;
            pll_req <= 1'b1;
            state <= ST_PLL;
          end
        end
        ST_PLL: begin
          if (pll_sync) begin
            conv_req <= 1'b1;
            state <= ST_CONV;
          end
        end
        ST_CONV: begin
          if (conv_done) begin
            state <= ST_SLOT;
          end
        end
        ST_SLOT: begin
          if (slot_ticks >= 5'(SLOT_TICKS)) begin
            if (idx == 5'(ENTRIES - 1)) begin
              done_pulse <= 1'b1;
              bias_sw <= 3'h0;
              pll_req <= 1'b0;
              sleep_cnt <= sleep_ticks(conv_ctrl_one[SLEEP_LSB +: 3]);
              state <= ST_SLEEP;
            end else begin
              idx <= idx + 5'h1;
              state <= ST_LOAD;
            end
          end
        end
        ST_SLEEP: begin
          if (sleep_cnt == 10'h0) begin
            idx <= 5'h0;
            state <= round_start_bit ? ST_LOAD : ST_IDLE;
          end else if (tb_tick) begin
            sleep_cnt <= sleep_cnt - 10'h1;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ===================================================================
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  sequence s_marker_seen;
    state == ST_DECODE && tbl_seq_q[4:0] == END_MARKER && conv_enable_bit;
  endsequence

  sequence s_entry_seen;
    state == ST_DECODE && tbl_seq_q[4:0] != END_MARKER && conv_enable_bit;
  endsequence

  chk_start_walk: assert property (
    state == ST_IDLE && conv_enable_bit && round_start_bit |=> state == ST_LOAD && idx == 5'h0)
    else $error("round did not start at entry zero");
  chk_end_marker: assert property (
    s_marker_seen |=> state == ST_SLEEP && !conv_req ##1 round_done_flag)
    else $error("end marker did not close the round");
  chk_entry_drive: assert property (
    s_entry_seen |=> bias_sw == $past(tbl_seq_q[7:5]) && conv_chan == $past(tbl_seq_q[4:0]))
    else $error("bias or channel not taken from entry");
  // the stored word, read back through the sequencer port, keeps gain on top
  chk_result_gain: assert property (
    res_we && conv_enable_bit |=> ##1 res_seq_q == {$past(conv_gain, 2), $past(conv_data, 2)})
    else $error("result word lost the gain bit");
  chk_irq_gate: assert property (
    chip_irq_out |-> $past(top_flag) && !$past(top_mask) && $past(round_done_flag) &&
      !$past(round_done_mask))
    else $error("interrupt raised without unmasked flags");
  chk_abort_idle: assert property (
    !conv_enable_bit |=> state == ST_IDLE && idx == 5'h0 && !done_pulse)
    else $error("disable did not abort the round");
  chk_pll_first: assert property (
    conv_req |-> pll_req && $past(pll_sync))
    else $error("conversion started without pll");
  chk_flag_hold: assert property (
    round_done_flag && !(bus_wr && wb_adr_i == REG_IRQ_STATUS) |=> round_done_flag)
    else $error("done flag dropped without clear");
  chk_slot_budget: assert property (
    state == ST_SLOT ##1 state == ST_LOAD |-> $past(slot_ticks) >= 5'(SLOT_TICKS))
    else $error("slot left before its time");
  chk_sleep_end: assert property (
    state == ST_SLEEP && sleep_cnt == 10'h0 && conv_enable_bit |=> state != ST_SLEEP)
    else $error("sleep overran its count");
  chk_unit_reset: assert property (
    $rose(arst_n) |-> !result_unit_select)
    else $error("unit select not zero after reset");
endmodule
`default_nettype wire

//--- sim/adc_round_robin_sequencer_tb.sv
// self-checking bench for the round-robin converter sequencer
`timescale 1ns/1ps
`default_nettype none
module adc_round_robin_sequencer_tb
  import adc_seq_pkg::*;
;
  // =====================================================================
  // signals and bench state
  logic core_clk, arst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [11:0] wb_adr_i;
  logic [3:0] wb_sel_i, alt_chan_en;
  logic [31:0] wb_dat_i, wb_dat_o, rdat;
  logic conv_power_en, conv_req, result_unit_select, conv_done, conv_gain;
  logic pll_req, pll_active, chip_irq_out, hold_done;
  logic [4:0] conv_chan;
  logic [2:0] bias_sw;
  logic [9:0] conv_data, code;
  logic [4:0] seen_chan [8];
  logic [2:0] seen_bias [8];
  logic seen_pll [8];
  int req_cyc [8];
  int n_conv, dly, cycles, n_errors, total_checks;
  localparam int TICK = 610; // clocks per time-base tick

  adc_round_robin_sequencer adc_round_robin_sequencer_inst (
    .core_clk(core_clk), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .conv_power_en(conv_power_en),
    .conv_req(conv_req), .conv_chan(conv_chan), .bias_sw(bias_sw),
    .result_unit_select(result_unit_select), .alt_chan_en(alt_chan_en),
    .conv_done(conv_done), .conv_data(conv_data), .conv_gain(conv_gain),
    .pll_req(pll_req), .pll_active(pll_active), .chip_irq_out(chip_irq_out)
  );

  // clock, 50 ns period
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // =====================================================================
  // converter and pll stand-in, cycle counter and timeout
  always @(posedge core_clk) begin
    cycles++;
    pll_active <= pll_req;
    conv_done <= 1'b0;
    if (conv_req === 1'b1) begin
      seen_chan[n_conv] = conv_chan;
      seen_bias[n_conv] = bias_sw;
      seen_pll[n_conv] = pll_req;
      req_cyc[n_conv] = cycles;
      n_conv++;
      dly = 4;
    end else if (hold_done) begin
      dly = 0; // a stalled conversion is simply dropped
    end else if (dly > 1) begin
      dly--;
    end else if (dly == 1) begin
      dly = 0;
      conv_done <= 1'b1;
      conv_data <= code;
      conv_gain <= code[0]; // gain follows the code parity
      code = code + 10'h001;
    end
    if (cycles == 95000) begin
      n_errors++;
      $display("mismatch run_time expected below 95000 seen limit");
      end_sim();
    end
  end

  // =====================================================================
  // shared tasks
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wb(input logic we, input logic [11:0] adr, input logic [31:0] wd);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= wd;
    wb_sel_i <= 4'hf;
    @(posedge core_clk);
    while (wb_ack_o !== 1'b1 && n < 20) begin
      @(posedge core_clk);
      n++;
    end
    chk("wb_ack_o", 32'h1, {31'h0, wb_ack_o});
    rdat = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic rd_chk(input string what, input logic [11:0] adr, input logic [31:0] exp);
    wb(1'b0, adr, 32'h0);
    chk(what, exp, rdat);
  endtask

  // poll the done flag, about 100 cycles apart
  task automatic wait_done();
    int n;
    for (n = 0; n < 500; n++) begin
      wb(1'b0, REG_IRQ_STATUS, 32'h0);
      if (rdat[0] === 1'b1) break;
      repeat (100) @(posedge core_clk);
    end
  endtask

  task automatic wait_conv(input int k);
    int n;
    for (n = 0; n < 40000 && n_conv < k; n++) @(posedge core_clk);
  endtask

  // =====================================================================
  // scenarios
  task automatic t_reset();
    rd_chk("ctrl", REG_CTRL_ONE, 32'h0);
    rd_chk("vendor_ctrl", REG_VENDOR_CTRL, 32'h0);
    rd_chk("chan_enable", REG_CHAN_ENABLE, 32'h0);
    chk("unit_out", 32'h0, {31'h0, result_unit_select});
    chk("irq_out", 32'h0, {31'h0, chip_irq_out});
  endtask

  task automatic t_regs();
    wb(1'b1, REG_VENDOR_CTRL, 32'h1);
    chk("unit_out", 32'h1, {31'h0, result_unit_select});
    wb(1'b1, REG_VENDOR_CTRL, 32'h0);
    chk("unit_out", 32'h0, {31'h0, result_unit_select});
    wb(1'b1, REG_CHAN_ENABLE, 32'ha);
    chk("alt_en", 32'ha, {28'h0, alt_chan_en});
    wb(1'b1, REG_CHAN_ENABLE, 32'h5);
    chk("alt_en", 32'h5, {28'h0, alt_chan_en});
    wb(1'b1, 12'h040, 32'hff);
    rd_chk("unmapped", 12'h040, 32'h0);
  endtask

  // two conversions, then the end marker; sleep code 1 is 32 ticks
  task automatic t_round();
    wb(1'b1, TABLE_BASE, 32'haa);
    wb(1'b1, TABLE_BASE + 12'h004, 32'h56);
    wb(1'b1, TABLE_BASE + 12'h008, 32'h1f);
    wb(1'b1, REG_CTRL_ONE, 32'h1);
    chk("power_en", 32'h1, {31'h0, conv_power_en});
    wb(1'b1, REG_CTRL_ONE, 32'h7);
    wait_done();
    chk("conv_count", 32'd2, n_conv);
    chk("chan0", 32'h0a, {27'h0, seen_chan[0]});
    chk("bias0", 32'h5, {29'h0, seen_bias[0]});
    chk("chan1", 32'h16, {27'h0, seen_chan[1]});
    chk("bias1", 32'h2, {29'h0, seen_bias[1]});
    chk("pll_at_req", 32'h1, {31'h0, seen_pll[0]});
    chk("slot_len", 32'h1, {31'h0, (req_cyc[1] - req_cyc[0]) inside {[14*TICK:17*TICK]}});
    rd_chk("result0", RESULT_BASE, 32'h100);
    rd_chk("result1", RESULT_BASE + 12'h004, 32'h501);
    rd_chk("top_flag", REG_TOP_IRQ, 32'h2);
    repeat (2) @(posedge core_clk);
    chk("irq_out", 32'h1, {31'h0, chip_irq_out});
    wb(1'b1, REG_TOP_MASK, 32'h2);
    repeat (2) @(posedge core_clk);
    chk("irq_topmask", 32'h0, {31'h0, chip_irq_out});
    wb(1'b1, REG_TOP_MASK, 32'h0);
    wb(1'b1, REG_IRQ_MASK, 32'h1);
    repeat (2) @(posedge core_clk);
    chk("irq_masked", 32'h0, {31'h0, chip_irq_out});
    wb(1'b1, REG_IRQ_MASK, 32'h0);
    repeat (2) @(posedge core_clk);
    chk("irq_unmasked", 32'h1, {31'h0, chip_irq_out});
    rd_chk("done_held", REG_IRQ_STATUS, 32'h1);
    wb(1'b1, REG_IRQ_STATUS, 32'h1);
    wb(1'b1, REG_TOP_IRQ, 32'h2);
    repeat (2) @(posedge core_clk);
    chk("irq_cleared", 32'h0, {31'h0, chip_irq_out});
    rd_chk("done_clear", REG_IRQ_STATUS, 32'h0);
  endtask

  // the round repeats after sleeping; stall it and disable mid-conversion
  task automatic t_abort();
    hold_done = 1'b1;
    wait_conv(3);
    chk("restart_chan", 32'h0a, {27'h0, seen_chan[2]});
    chk("sleep_gap", 32'h1, {31'h0, (req_cyc[2] - req_cyc[1]) inside {[45*TICK:49*TICK]}});
    wb(1'b1, REG_CTRL_ONE, 32'h0);
    rd_chk("seq_status", REG_SEQ_STATUS, 32'h0);
    chk("power_off", 32'h0, {31'h0, conv_power_en});
    rd_chk("no_done", REG_IRQ_STATUS, 32'h0);
    hold_done = 1'b0;
  endtask

  // a fresh round overwrites the old results
  task automatic t_rerun();
    wb(1'b1, REG_CTRL_ONE, 32'h1);
    wb(1'b1, REG_CTRL_ONE, 32'h7);
    wait_done();
    chk("conv_count", 32'd5, n_conv);
    rd_chk("result0_new", RESULT_BASE, 32'h102);
    rd_chk("result1_new", RESULT_BASE + 12'h004, 32'h503);
  endtask

  task automatic end_sim();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // =====================================================================
  // main sequence
  initial begin
    arst_n = 1'b0;
    {wb_cyc_i, wb_stb_i, wb_we_i, conv_done, conv_gain, pll_active, hold_done} = '0;
    wb_adr_i = 12'h000;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
    conv_data = 10'h000;
    code = 10'h100;
    {n_conv, dly, cycles, n_errors, total_checks} = '0;
    repeat (6) @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    t_reset();
    t_regs();
    t_round();
    t_abort();
    t_rerun();
    end_sim();
  end
endmodule
`default_nettype wire
